// ==== bench/stdp_dte_model.sv ====
/* dte partner model: transmit clock and data toward the port.
   assumes: driven from the bench top, same sys_clk as the port. */
module stdp_dte_model #(
  parameter int HALF = 4 // cycles per high level, low one more, 2.8 Mbps at 25 MHz
) (
  input wire logic sys_clk,
  input wire logic follow,
  input wire logic int_tx_clk_out,
  output logic ext_tx_clk,
  output logic tx_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_d = 1'h0; // last seen internal clock level
  initial begin
    ext_tx_clk = 1'h0;
    tx_data_in = 1'h1;
  end
  // follow mode: new bit on each internal clock fall
  always @(posedge sys_clk) begin
    ref_d <= int_tx_clk_out;
    if (follow && ref_d && !int_tx_clk_out) begin
      tx_data_in <= ~tx_data_in;
    end
  end
  // one clocked frame, msb first; the clock stands still between
  // frames; slip moves data onto the rising edge
  task automatic send(input logic [7:0] b, input logic slip);
    for (int i = 7; i >= 0; i--) begin
      @(posedge sys_clk);
      tx_data_in <= b[i];
      ext_tx_clk <= slip;
      repeat (HALF) @(posedge sys_clk);
      ext_tx_clk <= ~slip;
      repeat (HALF) @(posedge sys_clk);
      ext_tx_clk <= 1'h0;
    end
  endtask
endmodule // stdp_dte_model

// ==== bench/stdp_port_asserts.sv ====
/* checker: apb timing and link pulse relations at the port pins.
   assumes: bound to stdp_port from the bench top. */
module stdp_port_chk (
  input wire sys_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rts_in,
  input wire cts_out,
  input wire tx_bit_valid,
  input wire rx_clk_out,
  input wire rx_data_out,
  input wire rx_bit_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire acc = psel && penable; // access phase
  wire mapped = (paddr <= 8'h14) && (paddr[1:0] == 2'h0);
  chk_zero_wait: assert property (acc |-> pready)
    else $error("pready missing in access");
  chk_no_early: assert property (!penable |-> !pready)
    else $error("pready outside access");
  chk_err_unmap: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped address");
  chk_err_map: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped address");
  chk_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved without setup");
  chk_tx_pulse: assert property (tx_bit_valid |=> !tx_bit_valid)
    else $error("tx valid longer than one cycle");
  chk_ready_fall: assert property (
    rx_bit_ready |-> !rx_clk_out && $past(rx_clk_out))
    else $error("rx bit taken off the clock fall");
  chk_rx_align: assert property (
    $changed(rx_data_out) |-> $past(rx_bit_ready))
    else $error("rx data moved off its launch cycle");
  chk_cts_follow: assert property (
    $rose(rts_in) ##1 rts_in [*3] |-> cts_out)
    else $error("cts did not follow rts");
  cover property (tx_bit_valid);
  cover property (acc && pslverr);
  cover property ($fell(rts_in));
endmodule // stdp_port_chk

// ==== bench/tb_sync_terrestrial_data_port.sv ====
/* self-checking bench of the terrestrial data port over apb.
   assumes: stdp_port, stdp_dte_model and stdp_port_chk compiled first. */
module tb_sync_terrestrial_data_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, follow = 1'h0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, irq, ext_tx_clk, tx_data_in, int_tx_clk_out;
  logic rx_clk_out, rx_data_out, cts_out, tx_bit, tx_bit_valid;
  logic rx_bit_ready, carrier_on;
  logic rts_in = 1'h1, dtr_in = 1'h1, rx_bit = 1'h1, rx_bit_valid = 1'h0;
  int err_total = 0, compares = 0, cyc = 0, n;
  stdp_port i_stdp_port (.*);
  stdp_dte_model #(.HALF(4)) i_stdp_dte_model (.*);
  initial forever #20 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard, well above the planned run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    cmp(q, e);
  endtask
  // waits for the edge that takes an rx bit, bounded
  task automatic wait_ready();
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rx_bit_ready !== 1'h1 && n < 1000);
    cmp(rx_bit_ready, 32'h1);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rd_cmp(8'h00, 32'h0);
    rd_cmp(8'h04, 32'h007D007D);
    rd_cmp(8'h08, 32'h0);
    rd_cmp(8'h0C, 32'h0);
    rd_cmp(8'h40, 32'h0);
    cmp(err, 32'h1);
  endtask
  task automatic t_ext_tx();
    apb(1'h1, 8'h00, 32'h4);
    i_stdp_dte_model.send(8'hA5, 1'h0);
    cmp(tx_bit, 32'h1);
    apb(1'h0, 8'h14, 32'h0);
    cmp(q[7:0], 32'hA5);
    rd_cmp(8'h08, 32'h0);
  endtask
  // data edges on the sampling edge force one flip, then stay clean
  task automatic t_slip();
    apb(1'h1, 8'h0C, 32'h1);
    i_stdp_dte_model.send(8'h96, 1'h1);
    repeat (8) @(posedge sys_clk);
    cmp(irq, 32'h1);
    rd_cmp(8'h08, 32'h1);
    repeat (2) @(posedge sys_clk);
    cmp(irq, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    cmp(q[2], 32'h1);
    i_stdp_dte_model.send(8'h69, 1'h1);
    repeat (8) @(posedge sys_clk);
    rd_cmp(8'h08, 32'h0);
    apb(1'h0, 8'h14, 32'h0);
    cmp(q[7:0], 32'h69);
  endtask
  task automatic t_int_tx();
    apb(1'h1, 8'h04, 32'h00060004);
    // first pass internal timing, second pass receive timing
    for (int m = 0; m < 2; m++) begin
      apb(1'h1, 8'h00, m ? 32'h2 : 32'h0);
      follow <= 1'h1;
      repeat (480) @(posedge sys_clk);
      follow <= 1'h0;
      apb(1'h0, 8'h14, 32'h0);
      cmp(q === 32'h55555555 || q === 32'hAAAAAAAA, 32'h1);
    end
    // rx-timed transmit clock must be the receive clock itself
    repeat (24) begin
      @(negedge sys_clk);
      cmp(int_tx_clk_out, rx_clk_out);
    end
  endtask
  task automatic t_alarm();
    apb(1'h1, 8'h00, 32'h8);
    apb(1'h1, 8'h0C, 32'h2);
    apb(1'h0, 8'h08, 32'h0);
    dtr_in <= 1'h0;
    repeat (6) @(posedge sys_clk);
    cmp(irq, 32'h1);
    rd_cmp(8'h08, 32'h2);
    repeat (2) @(posedge sys_clk);
    cmp(irq, 32'h0);
    apb(1'h1, 8'h0C, 32'h0);
    rts_in <= 1'h0;
    repeat (6) @(posedge sys_clk);
    cmp(irq, 32'h0);
    rd_cmp(8'h08, 32'h2);
    rts_in <= 1'h1;
    dtr_in <= 1'h1;
  endtask
  task automatic t_carrier();
    apb(1'h1, 8'h00, 32'h10);
    rts_in <= 1'h0;
    repeat (6) @(posedge sys_clk);
    cmp(carrier_on, 32'h0);
    rts_in <= 1'h1;
    repeat (6) @(posedge sys_clk);
    cmp(carrier_on, 32'h1);
    apb(1'h1, 8'h00, 32'h0);
    repeat (6) @(posedge sys_clk);
    cmp(carrier_on, 32'h0);
    apb(1'h1, 8'h00, 32'h20);
    repeat (6) @(posedge sys_clk);
    cmp(carrier_on, 32'h1);
  endtask
  // four real bits, then two with valid low that must launch idle 1
  task automatic t_rx();
    logic [5:0] pat;
    pat = 6'h29;
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      rx_bit <= pat[i];
      rx_bit_valid <= (i < 4);
      wait_ready();
      @(negedge sys_clk);
      cmp(rx_data_out, (i < 4) ? pat[i] : 1'h1);
    end
  endtask
  task automatic t_rate();
    apb(1'h1, 8'h04, 32'h00010001);
    wait_ready();
    wait_ready();
    cmp(n, 32'h4);
    apb(1'h1, 8'h00, 32'h1);
    wait_ready();
    wait_ready();
    cmp(n, 32'hFA);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    nrst <= 1'h1;
    t_regs();
    t_ext_tx();
    t_slip();
    t_int_tx();
    t_alarm();
    t_carrier();
    t_rx();
    t_rate();
    tally_and_finish();
  end
endmodule // tb_sync_terrestrial_data_port
bind stdp_port stdp_port_chk i_stdp_port_chk (.*);

// ==== src/stdp_clkdiv.v ====
/*
 * clock divider: makes a square clock level plus one-cycle rise and fall
 * pulses from sys_clk, with a programmable half period.
 * assumes: half is at least 1 and is stable or changes between periods.
 */
module stdp_clkdiv #(
  parameter W = 16 // width of the half period count
) (
  input wire sys_clk,
  input wire nrst,
  input wire [W-1:0] half,
  output reg clk_out,
  output reg rise,
  output reg fall
);

  // cycles spent in the current half period
  reg [W-1:0] cnt_reg;

  // ----------------------------------------------------------------------
  // half period counter and toggle
  // ----------------------------------------------------------------------
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= {W{1'b0}};
      clk_out <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else if (cnt_reg + {{(W-1){1'b0}}, 1'b1} >= half) begin
      // end of half period: toggle and flag the edge
      cnt_reg <= {W{1'b0}};
      clk_out <= ~clk_out;
      rise <= ~clk_out;
      fall <= clk_out;
    end else begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
      rise <= 1'b0;
      fall <= 1'b0;
    end
  end

endmodule // stdp_clkdiv

// ==== src/stdp_port.v ====
/*
 * synchronous terrestrial data port: samples DTE transmit data on an
 * automatically chosen clock phase, makes the internal transmit clock and
 * the receive clock, launches receive data, watches RTS and DTR, gates the
 * carrier, and exposes control and status over an APB slave.
 * assumes: one clock sys_clk at 25 MHz; pins are plain levels, active high;
 * the modulator takes tx bits and the demodulator offers rx bits.
 */
// Local design decisions: the APB register port and the register offsets.
`include "stdp_regs.vh"

module stdp_port #(
  parameter GUARD = 8'h01, // a data edge must precede sampling by more than this many cycles
  parameter DW = 16        // divider half period width
) (
  input wire sys_clk,
  input wire nrst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq,
  // dte pins
  input wire ext_tx_clk,
  input wire tx_data_in,
  input wire rts_in,
  input wire dtr_in,
  output wire int_tx_clk_out,
  output wire rx_clk_out,
  output reg rx_data_out,
  output reg cts_out,
  // modem side
  output reg tx_bit,
  output reg tx_bit_valid,
  input wire rx_bit,
  input wire rx_bit_valid,
  output wire rx_bit_ready,
  output reg carrier_on
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  localparam integer V35_HALF_I = `STDP_HALF_MIN(`STDP_V35_BPS);
  localparam integer RS232_HALF_I = `STDP_HALF_MIN(`STDP_RS232_BPS);
  // the floors are worked out wide, then cut to the divider width
  localparam [DW-1:0] V35_HALF = V35_HALF_I[DW-1:0];
  localparam [DW-1:0] RS232_HALF = RS232_HALF_I[DW-1:0];
  localparam [3:0] PIN_CLK = 4'h1; // synchroniser lane masks
  localparam [3:0] PIN_DAT = 4'h2;
  localparam [3:0] PIN_RTS = 4'h4;
  localparam [3:0] PIN_DTR = 4'h8;

  reg [`STDP_CTRL_W-1:0] ctrl_reg; // software control
  reg [31:0] div_reg; // tx and rx half periods
  reg [`STDP_EV_W-1:0] status_reg; // sticky events
  reg [`STDP_EV_W-1:0] status_next;
  reg [`STDP_EV_W-1:0] mask_reg; // interrupt mask
  reg [31:0] txshift_reg; // last sampled tx bits
  reg [3:0] s1_reg; // synchroniser first stage
  reg [3:0] s2_reg; // synchroniser second stage
  reg [1:0] iref_reg; // internal clock delayed to match pins
  reg ref_prev_reg; // previous reference clock level
  reg data_prev_reg; // previous data level
  reg [7:0] since_reg; // cycles since last data change
  reg phase_reg; // 0 samples on rising, 1 on falling
  reg rts_prev_reg;
  reg dtr_prev_reg;
  reg [DW-1:0] tx_half;
  reg [DW-1:0] rx_half;
  reg ref_lvl;
  wire [1:0] src;
  wire rs232;
  wire [DW-1:0] half_min;
  wire txd_clk;
  wire rxd_clk;
  wire rxd_fall;
  wire ref_rise;
  wire ref_fall;
  wire samp;
  wire dchg;
  wire slip_ev;
  wire alarm_ev;
  wire alarm_lvl;
  wire acc;
  wire rd_clr;
  wire mapped;

  assign src = ctrl_reg[`STDP_CTRL_SRC_HI:`STDP_CTRL_SRC_LO];
  assign rs232 = ctrl_reg[`STDP_CTRL_RS232];

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // only s2_reg is read below; the first stage feeds nothing else
  // two stages keep a metastable pin level away from the logic
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 4'h0;
      s2_reg <= 4'h0;
    end else begin
      s1_reg <= {dtr_in, rts_in, tx_data_in, ext_tx_clk};
      s2_reg <= s1_reg;
    end
  end

  // ----------------------------------------------------------------------
  // rate clamping and clock generation
  // ----------------------------------------------------------------------
  // the floor per electrical mode keeps software from overdriving the line
  assign half_min = rs232 ? RS232_HALF : V35_HALF;

  // clamp both half periods to the mode floor
  always @* begin
    tx_half = div_reg[DW-1:0];
    rx_half = div_reg[`STDP_DIV_RX_LO+DW-1:`STDP_DIV_RX_LO];
    if (tx_half < half_min) begin
      tx_half = half_min;
    end
    if (rx_half < half_min) begin
      rx_half = half_min;
    end
  end

  // internal transmit clock
  stdp_clkdiv #(.W(DW)) u_txdiv (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .half(tx_half),
    .clk_out(txd_clk),
    .rise(),
    .fall()
  );

  // receive clock toward the dte
  stdp_clkdiv #(.W(DW)) u_rxdiv (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .half(rx_half),
    .clk_out(rxd_clk),
    .rise(),
    .fall(rxd_fall)
  );

  // rx-timed transmit follows the receive clock
  assign int_tx_clk_out = (src == `STDP_SRC_RX) ? rxd_clk : txd_clk;
  assign rx_clk_out = rxd_clk;

  // ----------------------------------------------------------------------
  // receive data launch
  // ----------------------------------------------------------------------
  // launching on the falling edge centres data under the rising edge
  assign rx_bit_ready = rxd_fall;

  // drive the next rx bit, mark idle with ones when none is offered
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_data_out <= 1'b1;
    end else if (rxd_fall) begin
      rx_data_out <= rx_bit_valid ? rx_bit : 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // reference clock selection for the phase check
  // ----------------------------------------------------------------------
  // delay the internal clock by two stages so that it lines up with
  // data that came through the pin synchroniser
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      iref_reg <= 2'h0;
    end else begin
      iref_reg <= {iref_reg[0], int_tx_clk_out};
    end
  end

  // pick which clock the data is judged against
  always @* begin
    if (src == `STDP_SRC_EXT) begin
      ref_lvl = |(s2_reg & PIN_CLK);
    end else begin
      ref_lvl = iref_reg[1];
    end
  end

  assign ref_rise = ref_lvl & ~ref_prev_reg;
  assign ref_fall = ~ref_lvl & ref_prev_reg;
  assign samp = phase_reg ? ref_fall : ref_rise;
  assign dchg = (|(s2_reg & PIN_DAT)) ^ data_prev_reg;
  // trade-off: a short guard keeps fast clocks usable, but data edges
  // that come just outside it pass without a warning
  // a data edge inside the guard window means the phase is wrong
  assign slip_ev = samp & (dchg | (since_reg < GUARD));

  // ----------------------------------------------------------------------
  // phase tracking and transmit sampling
  // ----------------------------------------------------------------------
  // data is only taken at clock edges, never framed on start bits
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ref_prev_reg <= 1'b0;
      data_prev_reg <= 1'b0;
      since_reg <= 8'h00;
      phase_reg <= 1'b0;
      tx_bit <= 1'b0;
      tx_bit_valid <= 1'b0;
      txshift_reg <= 32'h00000000;
    end else begin
      ref_prev_reg <= ref_lvl;
      data_prev_reg <= |(s2_reg & PIN_DAT);
      // saturating age of the last data edge
      if (dchg) begin
        since_reg <= 8'h00;
      end else if (since_reg != 8'hFF) begin
        since_reg <= since_reg + 8'h01;
      end
      // swap to the opposite edge when data moves at the sample point
      if (slip_ev) begin
        phase_reg <= ~phase_reg;
      end
      tx_bit_valid <= samp;
      if (samp) begin
        tx_bit <= |(s2_reg & PIN_DAT);
        txshift_reg <= {txshift_reg[30:0], |(s2_reg & PIN_DAT)};
      end
    end
  end

  // ----------------------------------------------------------------------
  // control lines: alarm, carrier and cts
  // ----------------------------------------------------------------------
  assign alarm_lvl = ctrl_reg[`STDP_CTRL_ALARM_EN] &
    ~(|(s2_reg & PIN_RTS) & |(s2_reg & PIN_DTR));
  // event on either line going inactive while alarms are enabled
  assign alarm_ev = ctrl_reg[`STDP_CTRL_ALARM_EN] &
    ((rts_prev_reg & ~|(s2_reg & PIN_RTS)) |
     (dtr_prev_reg & ~|(s2_reg & PIN_DTR)));

  // carrier follows rts when selected, otherwise the manual bit
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rts_prev_reg <= 1'b0;
      dtr_prev_reg <= 1'b0;
      carrier_on <= 1'b0;
      cts_out <= 1'b0;
    end else begin
      rts_prev_reg <= |(s2_reg & PIN_RTS);
      dtr_prev_reg <= |(s2_reg & PIN_DTR);
      cts_out <= |(s2_reg & PIN_RTS);
      if (ctrl_reg[`STDP_CTRL_RTS_CARR]) begin
        carrier_on <= |(s2_reg & PIN_RTS);
      end else begin
        carrier_on <= ctrl_reg[`STDP_CTRL_CARR_MAN];
      end
    end
  end

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  // zero wait states: read data is prepared in the setup cycle
  assign acc = psel & penable;
  assign pready = acc;
  // read-only registers ignore writes without raising an error
  assign mapped = (paddr == `STDP_OFF_CTRL) || (paddr == `STDP_OFF_DIV) ||
    (paddr == `STDP_OFF_STATUS) || (paddr == `STDP_OFF_MASK) ||
    (paddr == `STDP_OFF_STATE) || (paddr == `STDP_OFF_TXSHIFT);
  assign pslverr = acc & ~mapped;
  assign rd_clr = acc & ~pwrite & (paddr == `STDP_OFF_STATUS);

  // sticky status: an event in the clearing cycle survives the clear
  always @* begin
    status_next = status_reg;
    if (rd_clr) begin
      status_next = {`STDP_EV_W{1'b0}};
    end
    if (slip_ev) begin
      status_next[`STDP_EV_SLIP] = 1'b1;
    end
    if (alarm_ev) begin
      status_next[`STDP_EV_ALARM] = 1'b1;
    end
  end

  // register writes, status update and read data capture
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= `STDP_CTRL_RST;
      div_reg <= `STDP_DIV_RST;
      mask_reg <= `STDP_EV_RST;
      status_reg <= `STDP_EV_RST;
      prdata <= 32'h00000000;
    end else begin
      status_reg <= status_next;
      if (acc && pwrite) begin
        if (paddr == `STDP_OFF_CTRL) begin
          ctrl_reg <= pwdata[`STDP_CTRL_W-1:0];
        end else if (paddr == `STDP_OFF_DIV) begin
          div_reg <= pwdata;
        end else if (paddr == `STDP_OFF_MASK) begin
          mask_reg <= pwdata[`STDP_EV_W-1:0];
        end
      end
      // capture in setup so the data stands through the access cycle
      if (psel && !penable && !pwrite) begin
        if (paddr == `STDP_OFF_CTRL) begin
          prdata <= {{(32-`STDP_CTRL_W){1'b0}}, ctrl_reg};
        end else if (paddr == `STDP_OFF_DIV) begin
          prdata <= div_reg;
        end else if (paddr == `STDP_OFF_STATUS) begin
          prdata <= {{(32-`STDP_EV_W){1'b0}}, status_next};
        end else if (paddr == `STDP_OFF_MASK) begin
          prdata <= {{(32-`STDP_EV_W){1'b0}}, mask_reg};
        end else if (paddr == `STDP_OFF_STATE) begin
          prdata <= {27'h0000000, alarm_lvl, carrier_on, phase_reg,
            |(s2_reg & PIN_DTR), |(s2_reg & PIN_RTS)};
        end else if (paddr == `STDP_OFF_TXSHIFT) begin
          prdata <= txshift_reg;
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

  // level interrupt from unmasked sticky bits
  // a masked event still stays visible in the status register
  assign irq = |(status_reg & mask_reg);

endmodule // stdp_port

// ==== src/stdp_regs.vh ====
/*
 * register map, field positions, reset values and timing figures of the
 * synchronous terrestrial data port.
 * assumes: included by bare name from the design files under src/.
 */
`ifndef STDP_REGS_VH
`define STDP_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define STDP_OFF_CTRL 8'h00
`define STDP_OFF_DIV 8'h04
`define STDP_OFF_STATUS 8'h08
`define STDP_OFF_MASK 8'h0C
`define STDP_OFF_STATE 8'h10
`define STDP_OFF_TXSHIFT 8'h14

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define STDP_CTRL_RS232 0
`define STDP_CTRL_SRC_LO 1
`define STDP_CTRL_SRC_HI 2
`define STDP_CTRL_ALARM_EN 3
`define STDP_CTRL_RTS_CARR 4
`define STDP_CTRL_CARR_MAN 5
`define STDP_CTRL_W 6
`define STDP_CTRL_RST 6'h00

// transmit clock source codes
`define STDP_SRC_INT 2'h0
`define STDP_SRC_RX 2'h1
`define STDP_SRC_EXT 2'h2

// ----------------------------------------------------------------------
// divider register: tx half period low, rx half period high
// ----------------------------------------------------------------------
`define STDP_DIV_RST 32'h007D007D
// first bit of the rx half period field
`define STDP_DIV_RX_LO 16

// ----------------------------------------------------------------------
// status / mask fields (sticky events)
// ----------------------------------------------------------------------
`define STDP_EV_SLIP 0
`define STDP_EV_ALARM 1
`define STDP_EV_W 2
`define STDP_EV_RST 2'h0

// ----------------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------------
`define STDP_CLK_HZ 25000000
`define STDP_V35_BPS 10000000
`define STDP_RS232_BPS 100000
// least half period in clock cycles, rounded up
`define STDP_HALF_MIN(bps) ((`STDP_CLK_HZ + 2 * (bps) - 1) / (2 * (bps)))

`endif
